/* File: shared/cms_pkg.sv */
//Contract
// - On channel discrepancy drive enable OFF, raise fault and discrepancy error.
// - Discrepancy error clears once inputs go inactive and then active again.
// - Discrepancy error also clears on a run, halt, run transition.
// - While muting, ignore the curtain and hold enable ON until end condition.
// - Four muting modes: parallel, forward sequential, bidirectional sequential, position.
// - Muting status rises only when all applicable start conditions hold together.
// - Muting start needs the curtain beam input active, light path clear.
// - Muting start needs no discrepancy, synchronisation or sequence error present.
// - Muting start needs all muting sensors seen OFF beforehand.
// - Parallel and sequential modes need the two sensors to detect in order.
// - Parallel and sequential modes need the detection gap inside the window.
// - Position mode skips order and window checks; starts when sensor turns ON.
// - Raise a sequence error when the two sensors detect out of order.
// - Raise a synchronisation error when the detection gap leaves the window.
// - Curtain going inactive before muting drives enable OFF.
// - Muting ends on the mode-specific sensor release.
// - At start of operation clear all errors and reset all timers.
package cms_pkg;
    // Controller scan period and core clock period
    localparam int unsigned SCAN_PERIOD_NS = 1000000;
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned SCAN_CYCLES    = SCAN_PERIOD_NS / CLK_PERIOD_NS;
    // Discrepancy time, in ns, as scans
    localparam int unsigned DISC_TIME_NS   = 30000000;
    localparam int unsigned DISC_SCANS     = DISC_TIME_NS / SCAN_PERIOD_NS;

    localparam int DIV_W   = 16;
    localparam int DISC_W  = 12;
    localparam int SYNC_W  = 8;

    // Muting sensor bit positions
    localparam int S11 = 0;
    localparam int S12 = 1;
    localparam int S21 = 2;
    localparam int S22 = 3;

    typedef enum logic [1:0] {
        MODE_PARALLEL = 2'h0,
        MODE_FWD_SEQ  = 2'h1,
        MODE_BIDIR    = 2'h2,
        MODE_POSITION = 2'h3
    } cms_mode_type;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_ARMED = 4'h2,
        ST_SYNC  = 4'h4,
        ST_MUTE  = 4'h8
    } cms_state_type;
endpackage

/* File: shared/cms_disc_if.sv */
`timescale 1ns/100ps
interface cms_disc_if;
    logic       scan_en;
    logic       run;
    logic       run_start;
    logic       complement;
    logic [1:0] ch;
    logic       beam_active;
    logic       disc_err;

    modport main (output scan_en, run, run_start, complement, ch,
                  input  beam_active, disc_err);
    modport chk  (input  scan_en, run, run_start, complement, ch,
                  output beam_active, disc_err);
endinterface

/* File: rtl/cms_discrepancy.sv */
`timescale 1ns/100ps
module cms_discrepancy #(
    parameter int unsigned DISC_SCANS = cms_pkg::DISC_SCANS
) (
    input  wire logic core_clk,   // Core clock
    input  wire logic rstn,       // Async reset, active low
    cms_disc_if.chk   dif         // Channel pair and verdict
);
    typedef struct packed {
        logic [cms_pkg::DISC_W-1:0] cnt;
        logic                       err;
        logic                       seen_off;
        logic                       halted;
        logic                       active;
    } cms_disc_state_type;

    cms_disc_state_type cur;
    cms_disc_state_type next_cur;

    logic agree;
    logic act;
    logic idle;

    always_comb begin
        // Complementary wiring means channel 2 is normally open
        agree    = dif.complement ? (dif.ch[0] != dif.ch[1]) : (dif.ch[0] == dif.ch[1]);
        act      = agree && dif.ch[0];
        idle     = agree && !dif.ch[0];
        next_cur = cur;
        if (!dif.run) begin
            next_cur.halted = 1'b1;
            next_cur.active = 1'b0;
        end
        if (dif.run_start) begin
            next_cur.cnt      = '0;
            if (cur.halted) begin
                next_cur.err = 1'b0;
            end
            next_cur.seen_off = 1'b0;
            next_cur.halted   = 1'b0;
        end else if (dif.run && dif.scan_en) begin
            if (agree) begin
                next_cur.cnt = '0;
            end else if (cur.cnt != cms_pkg::DISC_W'(DISC_SCANS)) begin
                next_cur.cnt = cur.cnt + 1'b1;
            end
            if (cur.err && idle) begin
                next_cur.seen_off = 1'b1;
            end
            if (cur.err && cur.seen_off && act) begin
                next_cur.err      = 1'b0;
                next_cur.seen_off = 1'b0;
            end
            // A zero discrepancy time disables the check
            if (!agree && DISC_SCANS != 0 &&
                cur.cnt + 1'b1 >= cms_pkg::DISC_W'(DISC_SCANS)) begin
                next_cur.err      = 1'b1;
                next_cur.seen_off = 1'b0;
            end
            next_cur.active = act && !next_cur.err;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign dif.beam_active = cur.active;
    assign dif.disc_err    = cur.err;
endmodule

/* File: rtl/cms_muting.sv */
`timescale 1ns/100ps
module cms_muting #(
    parameter int unsigned SCAN_CYCLES = cms_pkg::SCAN_CYCLES,
    parameter int unsigned DISC_SCANS  = cms_pkg::DISC_SCANS
) (
    input  wire logic                      core_clk,       // Core clock, 10 MHz
    input  wire logic                      rstn,           // Async reset, active low
    input  wire logic                      run_mode,       // 1 run, 0 halt
    input  wire logic [1:0]                curtain_beam_input, // Curtain channels 1 and 2
    input  wire logic                      cfg_complement, // Channel 2 is normally open
    input  wire logic [3:0]                mute_sensor,    // Sensors 11,12,21,22 ON = object
    input  wire logic [1:0]                cfg_mode,       // Muting mode select
    input  wire logic                      cfg_order_swap, // Expect sensor 12 before 11
    input  wire logic [cms_pkg::SYNC_W-1:0] cfg_sync_min,  // Least gap, scans
    input  wire logic [cms_pkg::SYNC_W-1:0] cfg_sync_max,  // Longest gap, scans
    output logic                           out_enable,     // Machine enable
    output logic                           fault_present,  // Any error present
    output logic                           disc_error,     // Curtain discrepancy error
    output logic                           seq_error,      // Sensor order error
    output logic                           sync_error,     // Sensor gap error
    output logic                           muting_status   // Muting in force
);
    typedef struct packed {
        logic [cms_pkg::DIV_W-1:0]  div;
        logic                       scan;
        logic                       run_prev;
        logic                       run_start;
        cms_pkg::cms_state_type     st;
        logic                       rev;
        logic [cms_pkg::SYNC_W-1:0] gap;
        logic                       seq_err;
        logic                       sync_err;
        logic                       mute;
        logic                       enable;
        logic                       fault;
        logic                       disc;
    } cms_top_state_type;

    cms_top_state_type cur;
    cms_top_state_type next_cur;
    cms_disc_if        dif ();

    cms_pkg::cms_mode_type mode;
    logic                  first_on;
    logic                  second_on;
    logic                  other_on;
    logic                  ended;
    logic                  errs;
    logic                  all_off;

    assign dif.scan_en    = cur.scan;
    assign dif.run        = run_mode;
    assign dif.run_start  = cur.run_start;
    assign dif.complement = cfg_complement;
    assign dif.ch         = curtain_beam_input;

    cms_discrepancy #(
        .DISC_SCANS (DISC_SCANS)
    ) u_disc (
        .core_clk (core_clk),
        .rstn     (rstn),
        .dif      (dif)
    );

    always_comb begin
        mode     = cms_pkg::cms_mode_type'(cfg_mode);
        all_off  = (mute_sensor == 4'h0);
        next_cur = cur;
        // Pair the two sensors that open the sequence; reverse entry uses 22 then 21
        if (cur.rev) begin
            first_on  = mute_sensor[cms_pkg::S22];
            second_on = mute_sensor[cms_pkg::S21];
        end else if (cfg_order_swap) begin
            first_on  = mute_sensor[cms_pkg::S12];
            second_on = mute_sensor[cms_pkg::S11];
        end else begin
            first_on  = mute_sensor[cms_pkg::S11];
            second_on = mute_sensor[cms_pkg::S12];
        end
        other_on = (mode == cms_pkg::MODE_BIDIR) &&
                   (mute_sensor[cms_pkg::S12] || mute_sensor[cms_pkg::S21]);
        unique case (mode)
            cms_pkg::MODE_PARALLEL: ended = !mute_sensor[cms_pkg::S11] ||
                                            !mute_sensor[cms_pkg::S12];
            cms_pkg::MODE_POSITION: ended = !mute_sensor[cms_pkg::S11];
            default: ended = cur.rev ? (mute_sensor[3:1] == 3'h0)
                                     : (mute_sensor[2:0] == 3'h0);
        endcase
        errs = dif.disc_err || cur.seq_err || cur.sync_err;

        // Scan divider: the muting state machine advances once per scan
        next_cur.scan      = 1'b0;
        next_cur.run_start = run_mode && !cur.run_prev;
        next_cur.run_prev  = run_mode;
        if (cur.div == cms_pkg::DIV_W'(SCAN_CYCLES - 1)) begin
            next_cur.div  = '0;
            next_cur.scan = 1'b1;
        end else begin
            next_cur.div = cur.div + 1'b1;
        end

        if (!run_mode) begin
            next_cur.st   = cms_pkg::ST_IDLE;
            next_cur.mute = 1'b0;
        end else if (cur.run_start) begin
            next_cur.st       = cms_pkg::ST_IDLE;
            next_cur.gap      = '0;
            next_cur.seq_err  = 1'b0;
            next_cur.sync_err = 1'b0;
            next_cur.mute     = 1'b0;
            next_cur.div      = '0;
        end else if (cur.scan) begin
            // Order and gap alarms stand until every sensor has cleared again
            if (all_off && cur.st != cms_pkg::ST_SYNC) begin
                next_cur.seq_err  = 1'b0;
                next_cur.sync_err = 1'b0;
            end
            unique case (cur.st)
                cms_pkg::ST_IDLE: begin
                    next_cur.rev = 1'b0;
                    if (all_off && dif.beam_active && !errs) begin
                        next_cur.st = cms_pkg::ST_ARMED;
                    end
                end
                cms_pkg::ST_ARMED: begin
                    next_cur.gap = '0;
                    if (!dif.beam_active || errs) begin
                        next_cur.st = cms_pkg::ST_IDLE;
                    end else if (mode == cms_pkg::MODE_POSITION) begin
                        if (mute_sensor[cms_pkg::S11]) begin
                            next_cur.st   = cms_pkg::ST_MUTE;
                            next_cur.mute = 1'b1;
                        end
                    end else if (first_on && second_on) begin
                        // Simultaneous detection is a zero gap
                        if (cfg_sync_min != '0) begin
                            next_cur.sync_err = 1'b1;
                            next_cur.st       = cms_pkg::ST_IDLE;
                        end else begin
                            next_cur.st   = cms_pkg::ST_MUTE;
                            next_cur.mute = 1'b1;
                        end
                    end else if (first_on) begin
                        next_cur.st = cms_pkg::ST_SYNC;
                    end else if (mode == cms_pkg::MODE_BIDIR &&
                                 mute_sensor[cms_pkg::S22]) begin
                        next_cur.rev = 1'b1;
                        next_cur.st  = cms_pkg::ST_SYNC;
                    end else if (second_on || other_on) begin
                        next_cur.seq_err = 1'b1;
                        next_cur.st      = cms_pkg::ST_IDLE;
                    end
                end
                cms_pkg::ST_SYNC: begin
                    if (!dif.beam_active || errs || !first_on) begin
                        next_cur.st = cms_pkg::ST_IDLE;
                    end else if (second_on) begin
                        if (cur.gap + 1'b1 < cfg_sync_min ||
                            cur.gap + 1'b1 > cfg_sync_max) begin
                            next_cur.sync_err = 1'b1;
                            next_cur.st       = cms_pkg::ST_IDLE;
                        end else begin
                            next_cur.st   = cms_pkg::ST_MUTE;
                            next_cur.mute = 1'b1;
                        end
                    end else if (cur.gap + 1'b1 > cfg_sync_max) begin
                        next_cur.sync_err = 1'b1;
                        next_cur.st       = cms_pkg::ST_IDLE;
                    end else begin
                        next_cur.gap = cur.gap + 1'b1;
                    end
                end
                cms_pkg::ST_MUTE: begin
                    // Curtain state is not consulted here; only the release or a
                    // discrepancy or a halt ends muting
                    if (ended || dif.disc_err) begin
                        next_cur.st   = cms_pkg::ST_IDLE;
                        next_cur.mute = 1'b0;
                    end
                end
            endcase
        end

        // Drop muting at once; waiting for the next scan would leave it standing
        // beside a raised discrepancy error
        if (dif.disc_err) begin
            next_cur.st   = cms_pkg::ST_IDLE;
            next_cur.mute = 1'b0;
        end

        // Discrepancy forces the safe state even in the middle of muting
        next_cur.enable = run_mode && !dif.disc_err &&
                          (next_cur.mute || dif.beam_active);
        next_cur.disc   = dif.disc_err;
        next_cur.fault  = dif.disc_err || next_cur.seq_err || next_cur.sync_err;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cur     <= '0;
            cur.st  <= cms_pkg::ST_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    assign out_enable    = cur.enable;
    assign fault_present = cur.fault;
    assign disc_error    = cur.disc;
    assign seq_error     = cur.seq_err;
    assign sync_error    = cur.sync_err;
    assign muting_status = cur.mute;
endmodule

/* File: dv/cms_field_model.sv */
`timescale 1ns/100ps
module cms_field_model (
    input  wire logic       cfg_complement, // Channel 2 normally open
    input  wire logic       clear,          // Light path clear
    input  wire logic       skew,           // Channel 2 disagrees
    input  wire logic [3:0] objects,        // Sensors seeing an object
    output logic      [1:0] beam,           // Curtain channels
    output logic      [3:0] sensors         // Sensor outputs
);
    logic [1:0] level;
    // An inverted second channel is what a real curtain shows on a wiring fault
    always_comb begin
        level = clear ? 2'h3 : 2'h0;
        level[1] = level[1] ^ cfg_complement ^ skew;
    end
    assign beam    = level;
    assign sensors = objects;
endmodule

/* File: dv/cms_muting_properties.sv */
`timescale 1ns/100ps
module cms_muting_checker #(
    parameter int unsigned SCAN_CYCLES = 4,
    parameter int unsigned DISC_SCANS  = 3
) (
    input wire logic       core_clk,           // Clock
    input wire logic       rstn,               // Reset
    input wire logic       run_mode,           // Run
    input wire logic [1:0] curtain_beam_input, // Curtain
    input wire logic       cfg_complement,     // Complement
    input wire logic [3:0] mute_sensor,        // Sensors
    input wire logic [1:0] cfg_mode,           // Mode
    input wire logic       cfg_order_swap,     // Order
    input wire logic       out_enable,         // Enable
    input wire logic       fault_present,      // Fault
    input wire logic       disc_error,         // Discrepancy
    input wire logic       seq_error,          // Order error
    input wire logic       sync_error,         // Gap error
    input wire logic       muting_status       // Muting
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire beam_ok = curtain_beam_input == (cfg_complement ? 2'h1 : 2'h3);
    wire any_err = disc_error | seq_error | sync_error;

    property p_disc_off;
        disc_error && $past(disc_error) |-> !out_enable && !muting_status;
    endproperty
    a_disc_off: assert property (p_disc_off) else $error("enable during discrepancy");
    property p_disc_flag;
        $rose(disc_error) |-> ##[0:1] fault_present;
    endproperty
    a_disc_flag: assert property (p_disc_flag) else $error("no fault flag");
    property p_fault_clr;
        !any_err [*2] |-> !fault_present;
    endproperty
    a_fault_clr: assert property (p_fault_clr) else $error("fault without error");
    property p_mute_ok;
        $rose(muting_status) |-> $past(beam_ok) && !$past(any_err);
    endproperty
    a_mute_ok: assert property (p_mute_ok) else $error("muting started badly");
    property p_mute_hold;
        muting_status && $past(muting_status) && !disc_error |-> out_enable;
    endproperty
    a_mute_hold: assert property (p_mute_hold) else $error("enable off in muting");
    property p_beam_off;
        (!muting_status && !beam_ok) [*8] |-> !out_enable;
    endproperty
    a_beam_off: assert property (p_beam_off) else $error("enable with beam cut");
    property p_run_clr;
        $rose(run_mode) |-> ##[1:4] !any_err;
    endproperty
    a_run_clr: assert property (p_run_clr) else $error("errors kept at start");
    property p_pos;
        $rose(muting_status) && cfg_mode == 2'h3 |-> $past(mute_sensor[0]);
    endproperty
    a_pos: assert property (p_pos) else $error("position start without sensor");
    property p_par_end;
        $fell(muting_status) && cfg_mode == 2'h0 && run_mode && !disc_error
            |-> $past(mute_sensor[1:0]) != 2'h3;
    endproperty
    a_par_end: assert property (p_par_end) else $error("muting dropped early");
    property p_seq;
        $rose(seq_error) && cfg_mode == 2'h0 && !cfg_order_swap
            |-> $past(mute_sensor[1:0]) == 2'h2;
    endproperty
    a_seq: assert property (p_seq) else $error("order error without cause");
    c_mute: cover property ($rose(muting_status));
    c_disc: cover property ($rose(disc_error));
    c_sync: cover property ($rose(sync_error));
endmodule

bind cms_muting cms_muting_checker #(
    .SCAN_CYCLES(SCAN_CYCLES),
    .DISC_SCANS(DISC_SCANS)
) u_chk (
    .core_clk, .rstn, .run_mode, .curtain_beam_input, .cfg_complement,
    .mute_sensor, .cfg_mode, .cfg_order_swap, .out_enable, .fault_present,
    .disc_error, .seq_error, .sync_error, .muting_status
);

/* File: dv/tb.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t outputs %h", $time, a); end end
module tb;
    localparam int unsigned SC = 4;
    logic                          core_clk = 1'b0;
    logic                          rstn = 1'b0;
    logic                          run_mode = 1'b0;
    logic                          cfg_complement = 1'b0;
    logic                          clear = 1'b1;
    logic                          skew = 1'b0;
    logic [3:0]                    objects = 4'h0;
    logic [1:0]                    cfg_mode = 2'h0;
    logic                          cfg_order_swap = 1'b0;
    logic [cms_pkg::SYNC_W-1:0]    cfg_sync_min = 8'h00;
    logic [cms_pkg::SYNC_W-1:0]    cfg_sync_max = 8'h04;
    logic [1:0]                    beam;
    logic [3:0]                    sensors;
    logic                          out_enable, fault_present, disc_error;
    logic                          seq_error, sync_error, muting_status;
    int                            n_mismatch = 0;
    int                            compares = 0;

    always #50 core_clk = ~core_clk;

    cms_field_model u_field (.cfg_complement, .clear, .skew, .objects, .beam, .sensors);
    cms_muting #(.SCAN_CYCLES(SC), .DISC_SCANS(3)) dut (
        .core_clk, .rstn, .run_mode, .curtain_beam_input(beam), .cfg_complement,
        .mute_sensor(sensors), .cfg_mode, .cfg_order_swap, .cfg_sync_min,
        .cfg_sync_max, .out_enable, .fault_present, .disc_error, .seq_error,
        .sync_error, .muting_status
    );

    task automatic results;
        if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Scan phase is unknown here, so each step spans whole scans plus two answer clocks
    task automatic scans(input int n);
        repeat (n * SC + 2) @(negedge core_clk);
    endtask
    task automatic put(input logic c, input logic [3:0] o, input int n);
        clear = c;
        objects = o;
        scans(n);
    endtask
    // Order: enable, fault, discrepancy, order error, gap error, muting
    task automatic expect_out(input logic [5:0] v);
        `CHK({out_enable, fault_present, disc_error, seq_error, sync_error, muting_status}, v)
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        results();
    end

    initial begin
        repeat (8) @(negedge core_clk);
        rstn = 1'b1;
        scans(1);
        expect_out(6'h00);
        run_mode = 1'b1;
        put(1'b1, 4'h0, 2);
        expect_out(6'h20);
        for (int m = 0; m < 4; m++) begin
            cfg_mode = m[1:0];
            put(1'b1, 4'h1, 2);
            if (m != 3) begin
                expect_out(6'h20);
                put(1'b1, 4'h3, 2);
            end
            expect_out(6'h21);
            put(1'b1, 4'h0, 2);
            expect_out(6'h20);
        end
        cfg_mode = 2'h0;
        put(1'b1, 4'h1, 2);
        put(1'b1, 4'h3, 2);
        put(1'b0, 4'h3, 2);
        expect_out(6'h21);
        put(1'b0, 4'h1, 2);
        expect_out(6'h00);
        put(1'b0, 4'h0, 2);
        put(1'b0, 4'h1, 2);
        put(1'b0, 4'h3, 2);
        expect_out(6'h00);
        put(1'b1, 4'h0, 2);
        cfg_order_swap = 1'b1;
        put(1'b1, 4'h2, 2);
        put(1'b1, 4'h3, 2);
        expect_out(6'h21);
        put(1'b1, 4'h0, 2);
        cfg_order_swap = 1'b0;
        put(1'b1, 4'h2, 2);
        expect_out(6'h34);
        put(1'b1, 4'h3, 2);
        expect_out(6'h34);
        put(1'b1, 4'h0, 2);
        expect_out(6'h20);
        put(1'b1, 4'h1, 6);
        expect_out(6'h32);
        put(1'b1, 4'h3, 2);
        expect_out(6'h32);
        put(1'b1, 4'h0, 2);
        skew = 1'b1;
        scans(5);
        expect_out(6'h18);
        skew = 1'b0;
        scans(2);
        expect_out(6'h18);
        put(1'b0, 4'h0, 2);
        put(1'b1, 4'h0, 2);
        expect_out(6'h20);
        skew = 1'b1;
        scans(5);
        skew = 1'b0;
        run_mode = 1'b0;
        scans(1);
        run_mode = 1'b1;
        scans(2);
        expect_out(6'h20);
        cfg_complement = 1'b1;
        put(1'b1, 4'h0, 2);
        expect_out(6'h20);
        cfg_sync_min = 8'h02;
        put(1'b1, 4'h3, 2);
        expect_out(6'h32);
        cfg_sync_min = 8'h00;
        put(1'b1, 4'h0, 2);
        put(1'b1, 4'h3, 2);
        expect_out(6'h21);
        put(1'b1, 4'h0, 2);
        cfg_mode = 2'h2;
        put(1'b1, 4'h8, 2);
        expect_out(6'h20);
        put(1'b1, 4'hC, 2);
        expect_out(6'h21);
        put(1'b1, 4'h0, 2);
        expect_out(6'h20);
        put(1'b1, 4'h4, 2);
        expect_out(6'h34);
        results();
    end
endmodule
